// File: rtl/query_rom_consts.svh
`ifndef QUERY_ROM_CONSTS_SVH
`define QUERY_ROM_CONSTS_SVH

// Byte offsets of the query entries on the register bus.
`define OFS_PAGE_EXP        8'h4c
`define OFS_BURST_COUNT     8'h4d
`define OFS_BURST_FIRST     8'h4e
`define OFS_BURST_SECOND    8'h4f
`define OFS_BURST_THIRD     8'h50
`define OFS_BURST_FOURTH    8'h51
`define OFS_PART_REGIONS    8'h52
`define OFS_IDENT_PART_LO   8'h53
`define OFS_IDENT_PART_HI   8'h54
`define OFS_OPS_WITHIN      8'h55
`define OFS_OPS_PROGRAM     8'h56
`define OFS_OPS_ERASE       8'h57
`define OFS_ERASE_REGIONS   8'h58

// Values returned by the page and burst entries.
`define VAL_PAGE_EXP        8'h03
`define VAL_BURST_COUNT     8'h04
`define VAL_BURST_FIRST     8'h01
`define VAL_BURST_SECOND    8'h02
`define VAL_BURST_THIRD     8'h03
`define VAL_BURST_FOURTH    8'h07

// Field layout of a burst entry and of the operation entries.
`define BURST_EXP_MSB       2
`define NIB_PROG_LSB        0
`define NIB_ERASE_LSB       4

// Avalon response codes.
`define RESP_OKAY           2'h0
`define RESP_DECODE_ERROR   2'h3

`endif

// File: rtl/query_rom_pkg.sv
package query_rom_pkg;

   // Answer phase of the bus slave.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ANSWER
   } bus_state_t;

   // All state of the query block.
   typedef struct packed {
      bus_state_t  state;
      logic [31:0] rdata;
      logic        rvalid;
   } rom_state_t;

endpackage : query_rom_pkg

// File: rtl/query_rom.sv
`timescale 1ns/1ns
`include "query_rom_consts.svh"

module query_rom #(
   parameter logic [7:0]  PART_REGIONS    = 8'h02,
   parameter logic [15:0] IDENT_PARTS     = 16'h0001,
   parameter logic [3:0]  WITHIN_PROG     = 4'h1,
   parameter logic [3:0]  WITHIN_ERASE    = 4'h1,
   parameter logic [3:0]  DURING_PROG_P   = 4'h0,
   parameter logic [3:0]  DURING_PROG_E   = 4'h0,
   parameter logic [3:0]  DURING_ERASE_P  = 4'h0,
   parameter logic [3:0]  DURING_ERASE_E  = 4'h0,
   parameter logic [7:0]  ERASE_REGIONS   = 8'h02
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   output logic [1:0]       response
);

   // ==========================================================
   // Entry table
   // ==========================================================
   // Thirteen byte entries, from the page entry up to the erase region count.
   localparam int ENTRY_COUNT = 13;

   // Per-entry view of the table; index zero holds the lowest offset.
   logic [7:0]             entry_offset [ENTRY_COUNT];
   logic [7:0]             entry_raw    [ENTRY_COUNT];
   logic [7:0]             entry_clean  [ENTRY_COUNT];
   logic [7:0]             entry_data   [ENTRY_COUNT];
   logic [ENTRY_COUNT-1:0] entry_burst;
   logic [ENTRY_COUNT-1:0] entry_match;
   logic [7:0]             entry_byte;
   logic                   entry_hit;

   // Offsets are listed one by one, so a hole in the map needs no new arithmetic.
   assign entry_offset[0]  = `OFS_PAGE_EXP;
   assign entry_offset[1]  = `OFS_BURST_COUNT;
   assign entry_offset[2]  = `OFS_BURST_FIRST;
   assign entry_offset[3]  = `OFS_BURST_SECOND;
   assign entry_offset[4]  = `OFS_BURST_THIRD;
   assign entry_offset[5]  = `OFS_BURST_FOURTH;
   assign entry_offset[6]  = `OFS_PART_REGIONS;
   assign entry_offset[7]  = `OFS_IDENT_PART_LO;
   assign entry_offset[8]  = `OFS_IDENT_PART_HI;
   assign entry_offset[9]  = `OFS_OPS_WITHIN;
   assign entry_offset[10] = `OFS_OPS_PROGRAM;
   assign entry_offset[11] = `OFS_OPS_ERASE;
   assign entry_offset[12] = `OFS_ERASE_REGIONS;

   // ==========================================================
   // Fixed capability bytes
   // ==========================================================
   // Page and burst figures are fixed by the read path, so nothing can corrupt them.
   // page exponent
   assign entry_raw[0] = `VAL_PAGE_EXP;
   assign entry_raw[1] = `VAL_BURST_COUNT;
   assign entry_raw[2] = `VAL_BURST_FIRST;
   assign entry_raw[3] = `VAL_BURST_SECOND;
   assign entry_raw[4] = `VAL_BURST_THIRD;
   assign entry_raw[5] = `VAL_BURST_FOURTH;

   // ==========================================================
   // Partition figures
   // ==========================================================
   // One byte per partition entry, built from the module parameters.
   logic [7:0] part_regions_byte;
   logic [7:0] ident_lo_byte;
   logic [7:0] ident_hi_byte;
   logic [7:0] ops_within_byte;
   logic [7:0] ops_program_byte;
   logic [7:0] ops_erase_byte;
   logic [7:0] erase_regions_byte;

   assign part_regions_byte = PART_REGIONS;

   assign ident_lo_byte = IDENT_PARTS[7:0];
   assign ident_hi_byte = IDENT_PARTS[15:8];

   always_comb begin
      ops_within_byte                       = 8'h00;
      ops_within_byte[`NIB_PROG_LSB +: 4]  = WITHIN_PROG;
      ops_within_byte[`NIB_ERASE_LSB +: 4] = WITHIN_ERASE;
   end

   always_comb begin
      ops_program_byte                       = 8'h00;
      ops_program_byte[`NIB_PROG_LSB +: 4]  = DURING_PROG_P;
      ops_program_byte[`NIB_ERASE_LSB +: 4] = DURING_PROG_E;
   end

   always_comb begin
      ops_erase_byte                       = 8'h00;
      ops_erase_byte[`NIB_PROG_LSB +: 4]  = DURING_ERASE_P;
      ops_erase_byte[`NIB_ERASE_LSB +: 4] = DURING_ERASE_E;
   end

   assign erase_regions_byte = ERASE_REGIONS;

   // Partition bytes take their slots in the table.
   assign entry_raw[6]  = part_regions_byte;
   assign entry_raw[7]  = ident_lo_byte;
   assign entry_raw[8]  = ident_hi_byte;
   assign entry_raw[9]  = ops_within_byte;
   assign entry_raw[10] = ops_program_byte;
   assign entry_raw[11] = ops_erase_byte;
   assign entry_raw[12] = erase_regions_byte;

   // ==========================================================
   // Per-entry decode
   // ==========================================================
   generate
      for (genvar i = 0; i < ENTRY_COUNT; i++) begin : g_entry
         assign entry_burst[i] = (entry_offset[i] >= `OFS_BURST_FIRST) &&
                                 (entry_offset[i] <= `OFS_BURST_FOURTH);

         assign entry_clean[i] = entry_burst[i] ? {5'h00, entry_raw[i][`BURST_EXP_MSB:0]} :
                                                  entry_raw[i];

         // One comparator per entry; the offsets differ, so at most one fires.
         assign entry_match[i] = (address == entry_offset[i]);

         // A silent entry adds zero to the merge below.
         assign entry_data[i] = entry_match[i] ? entry_clean[i] : 8'h00;
      end
   endgenerate

   // ==========================================================
   // Entry merge
   // ==========================================================
   // An OR tree instead of a priority chain keeps the read path one level deep.
   always_comb begin
      entry_byte = 8'h00;
      for (int k = 0; k < ENTRY_COUNT; k++) begin
         entry_byte = entry_byte | entry_data[k];
      end
   end

   // Any comparator firing makes the address a mapped entry.
   assign entry_hit = |entry_match;

   // ==========================================================
   // Request decode
   // ==========================================================
   query_rom_pkg::rom_state_t state_reg;
   query_rom_pkg::rom_state_t state_next;
   logic                      answering;
   logic                      read_take;
   logic                      write_take;
   logic                      unmapped_take;
   logic [31:0]               answer_word;

   // A request is taken in IDLE; while ANSWER holds, the same request is not taken twice.
   assign answering     = (state_reg.state == query_rom_pkg::ST_ANSWER);
   assign read_take     = read && !answering;
   assign write_take    = write && !read && !answering;
   // Only a read of an address outside the table is refused.
   assign unmapped_take = read_take && !entry_hit;

   assign answer_word = (read_take && entry_hit) ? {24'h000000, entry_byte} : 32'h0;

   // ==========================================================
   // Answer state machine
   // ==========================================================
   // One wait cycle per access: the request is seen in IDLE, answered in ANSWER.
   always_comb begin
      state_next        = state_reg;
      state_next.rvalid = 1'b0;
      case (state_reg.state)
         query_rom_pkg::ST_IDLE: begin
            if (read_take || write_take) begin
               state_next.state  = query_rom_pkg::ST_ANSWER;
               state_next.rdata  = answer_word;
               state_next.rvalid = unmapped_take;
            end
         end
         query_rom_pkg::ST_ANSWER: begin
            state_next.state = query_rom_pkg::ST_IDLE;
         end
         default: begin
            state_next.state = query_rom_pkg::ST_IDLE;
         end
      endcase
   end

   // Single state register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '{state: query_rom_pkg::ST_IDLE, rdata: 32'h0, rvalid: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Bus outputs
   // ==========================================================
   // Writes are ignored: the table is read only, so writedata and byteenable go unused.
   // Unmapped reads answer zero with a decode error.
   assign waitrequest = (read || write) && !answering;
   assign readdata    = state_reg.rdata;
   assign response    = state_reg.rvalid ? `RESP_DECODE_ERROR : `RESP_OKAY;

endmodule : query_rom

// File: verif/query_rom_chk.sv
`timescale 1ns/1ns
module query_rom_chk (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest
);
   // ==========
   // Entry checks.
   // A read is taken while waitrequest still stands, so the byte shows one edge later.
   wire tk = read && waitrequest;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_page_exp: assert property (tk && address == 8'h4c |=> readdata == 32'h3)
      else $error("page");
   chk_burst_num: assert property (tk && address == 8'h4d |=> readdata == 32'h4)
      else $error("count");
   chk_burst_resv: assert property (tk && address inside {[8'h4e:8'h51]}
      |=> readdata[7:3] == 5'h0)
      else $error("reserved");
   chk_burst_cont: assert property (tk && address == 8'h51 |=> readdata == 32'h7)
      else $error("cont");
   chk_burst_one: assert property (tk && address == 8'h4e |=> readdata == 32'h1)
      else $error("first");
   chk_burst_two: assert property (tk && address == 8'h4f |=> readdata == 32'h2)
      else $error("second");
   chk_burst_three: assert property (tk && address == 8'h50 |=> readdata == 32'h3)
      else $error("third");
   chk_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("upper");
endmodule : query_rom_chk
bind query_rom query_rom_chk u_query_rom_chk (.clk(clk), .rstn(rstn), .address(address),
   .read(read), .readdata(readdata), .waitrequest(waitrequest));

// File: verif/query_host.sv
`timescale 1ns/1ns
module query_host (
   input  wire logic        clk,
   input  wire logic        waitrequest,
   input  wire logic [31:0] readdata,
   input  wire logic [1:0]  response,
   output logic [7:0]       address,
   output logic             read,
   output logic             write,
   output logic [31:0]      writedata,
   output logic [3:0]       byteenable
);
   initial {address, read, write, writedata, byteenable} = '0;
   // The request is held until waitrequest is seen low; the answer is taken before release.
   task automatic xfer(input logic wr, input logic [7:0] a, output logic [33:0] ans);
      @(posedge clk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= 32'hffffffff;
      byteenable <= 4'hf;
      // Read right after the edge, so these are the values the slave showed at it.
      do @(posedge clk); while (waitrequest !== 1'b0);
      ans = {response, readdata};
      read <= 1'b0;
      write <= 1'b0;
   endtask : xfer
endmodule : query_host

// File: verif/query_rom_tb.sv
`timescale 1ns/1ns
module query_rom_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic read, write, waitrequest;
   logic [7:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   logic [1:0] response;
   logic [33:0] ans;
   int failures = 0;
   int tests_run = 0;
   query_rom u_query_rom (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .response(response));
   query_host u_query_host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
      .response(response), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable));
   initial forever #4 clk = ~clk;
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("failures %0d comparisons %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   // ==========
   // Scenarios.
   // Every entry from 4c to 58, back to back, with the default partition figures.
   task automatic test_entries();
      logic [7:0] exp [13] = '{8'h03, 8'h04, 8'h01, 8'h02, 8'h03, 8'h07, 8'h02, 8'h01,
                               8'h00, 8'h11, 8'h00, 8'h00, 8'h02};
      for (int i = 0; i < 13; i++) begin
         u_query_host.xfer(1'b0, 8'h4c + 8'(i), ans);
         check(ans, {26'h0, exp[i]});
      end
   endtask : test_entries
   // A write is accepted but must leave the entry untouched.
   task automatic test_write();
      u_query_host.xfer(1'b1, 8'h4c, ans);
      check(34'(ans[33:32]), 34'h0);
      u_query_host.xfer(1'b0, 8'h4c, ans);
      check(ans, 34'h3);
   endtask : test_write
   // Addresses beyond the table answer zero with an error code.
   task automatic test_unmapped();
      u_query_host.xfer(1'b0, 8'h59, ans);
      check(ans, {2'b11, 32'h0});
   endtask : test_unmapped
   // A mid-run reset clears the answer, and the first read after it is served normally.
   task automatic test_reset();
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      check({response, readdata}, 34'h0);
      rstn <= 1'b1;
      u_query_host.xfer(1'b0, 8'h4e, ans);
      check(ans, 34'h1);
   endtask : test_reset
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      test_entries();
      test_write();
      test_unmapped();
      test_reset();
      stop_test();
   end
   // Seventeen short transfers need well under a thousand cycles.
   initial begin
      repeat (1000) @(posedge clk);
      failures++;
      stop_test();
   end
endmodule : query_rom_tb
